// File: sssg_regs.vh
/*
 * Register offsets, field positions, reset values and decode constants of the
 * supply supervisor and speed guard.
 * Assumes it is included by bare name from each design file that needs it.
 */
`ifndef SSSG_REGS_VH
`define SSSG_REGS_VH

`define SSSG_ADDR_W          9
`define SSSG_DATA_W          8
`define SSSG_BASE_LIMIT      9'h0FF

`define SSSG_OFF_INT_EN0     9'h0E0
`define SSSG_OFF_WDT_CLR     9'h0E3
`define SSSG_OFF_CPU_FLAGS   9'h0F7
`define SSSG_OFF_SYS_CTRL    9'h0FF
`define SSSG_OFF_OSC_SPEED   9'h1E0
`define SSSG_OFF_VDET_CTRL   9'h1E3
`define SSSG_OFF_VCMP_STAT   9'h1E4

`define SSSG_SEL_INT_EN0     0
`define SSSG_SEL_WDT_CLR     1
`define SSSG_SEL_CPU_FLAGS   2
`define SSSG_SEL_SYS_CTRL    3
`define SSSG_SEL_OSC_SPEED   4
`define SSSG_SEL_VDET_CTRL   5
`define SSSG_SEL_VCMP_STAT   6
`define SSSG_SEL_COUNT       7

`define SSSG_RST_INT_EN0     8'h00
`define SSSG_RST_CPU_FLAGS   8'h02
`define SSSG_RST_SYS_CTRL    8'h10
`define SSSG_RST_OSC_SPEED   8'h00
`define SSSG_RST_VDET_CTRL   8'h00

`define SSSG_FLAGS_GIE_BIT   0
`define SSSG_FLAGS_EXT_BIT   4
`define SSSG_FLAGS_RW_MASK   8'h1F

`define SSSG_SCR_STOP_BIT    0
`define SSSG_SCR_SLEEP_BIT   3
`define SSSG_SCR_POR_BIT     4
`define SSSG_SCR_WDR_BIT     5
`define SSSG_SCR_GIRQ_BIT    7

`define SSSG_IEN_SUPPLY_BIT  0

`define SSSG_OSC_SPEED_LSB   0
`define SSSG_OSC_SLEEP_LSB   3
`define SSSG_OSC_NOBUZZ_BIT  5

`define SSSG_VDET_THR_LSB    0
`define SSSG_VDET_LEV_LSB    4
`define SSSG_VDET_RW_MASK    8'h37
`define SSSG_LEV_HIGH        2'h2
`define SSSG_THR_HIGH_LOWER  3'h6
`define SSSG_THR_HIGH_UPPER  3'h7

`define SSSG_VCMP_RESET_BIT  0
`define SSSG_VCMP_LOW_BIT    1

`endif

// File: sssg_sticky_flag.v
/*
 * One sticky flag that hardware sets and another party clears.
 * Assumes set and clear are synchronous one-cycle or level terms on clk_i.
 */
`timescale 1ns/1ns
module sssg_sticky_flag #(
	parameter RESET_VAL = 1'b0
) (
	// Clock and reset
	input  wire clk_i,
	input  wire reset_n_i,
	// Control
	input  wire set_i,
	input  wire clr_i,
	// State
	output wire flag_o
);
	reg flag_reg;
	reg flag_next;

	// A set that lands in the clearing cycle wins so no event is lost.
	always @* begin
		flag_next = flag_reg;
		if (clr_i)
			flag_next = 1'b0;
		if (set_i)
			flag_next = 1'b1;
	end

	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			flag_reg <= RESET_VAL;
		else
			flag_reg <= flag_next;
	end

	assign flag_o = flag_reg;
endmodule // sssg_sticky_flag

// File: sssg_addr_decode.v
/*
 * Address decoder of the supervisor registers, one select per register.
 * Assumes the extended-space flag comes from the flags register of this block.
 */
`timescale 1ns/1ns
`include "sssg_regs.vh"
module sssg_addr_decode (
	// Access
	input  wire [`SSSG_ADDR_W-1:0]    addr_i,
	input  wire                       ext_space_i,
	// Decode
	output reg  [`SSSG_SEL_COUNT-1:0] sel_o
);
	reg ext_ok;

	always @* begin
		ext_ok = (addr_i <= `SSSG_BASE_LIMIT) | ext_space_i; // RULE1
		sel_o = {`SSSG_SEL_COUNT{1'b0}};
		sel_o[`SSSG_SEL_INT_EN0]   = ext_ok & (addr_i == `SSSG_OFF_INT_EN0);
		sel_o[`SSSG_SEL_WDT_CLR]   = ext_ok & (addr_i == `SSSG_OFF_WDT_CLR);
		sel_o[`SSSG_SEL_CPU_FLAGS] = ext_ok & (addr_i == `SSSG_OFF_CPU_FLAGS);
		sel_o[`SSSG_SEL_SYS_CTRL]  = ext_ok & (addr_i == `SSSG_OFF_SYS_CTRL);
		sel_o[`SSSG_SEL_OSC_SPEED] = ext_ok & (addr_i == `SSSG_OFF_OSC_SPEED);
		sel_o[`SSSG_SEL_VDET_CTRL] = ext_ok & (addr_i == `SSSG_OFF_VDET_CTRL);
		sel_o[`SSSG_SEL_VCMP_STAT] = ext_ok & (addr_i == `SSSG_OFF_VCMP_STAT);
	end
endmodule // sssg_addr_decode

// File: sssg_supervisor.v
/*
 * Supply supervisor and CPU speed guard: reset trip level, low-supply detector
 * threshold, comparator status, reset-cause flags, supply interrupt and
 * watchdog clear, all behind a plain register port.
 * Assumes the analog comparators and the watchdog deliver levels and pulses
 * that are already synchronous to clk_i, and that firmware is the only master.
 */
// Notes on behaviour
// (RULE1) Registers above 0xFF decode only while the extended-space flag is set, which firmware sets first.
// (RULE2) Writing binary 10 into the two-bit trip level field at 0x1E3 selects the high reset trip point.
// (RULE3) The three-bit threshold field sets the detector point, codes 110 and 111 being the two high ones.
// (RULE4) Bit 1 of the status at 0x1E4 reads 0 while the supply is above the threshold and 1 otherwise.
// (RULE5) Firmware programs the high trip level before any speed above 12 MHz.
// (RULE6) Power-on reset is asserted whenever the supply is below the selected trip level.
// (RULE7) Firmware selects a high threshold, waits for a clear debounced status, raises the trip, then goes to 24 MHz.
// (RULE8) Firmware may use the supply interrupt to drop to 12 MHz and lower the trip, restoring both later.
// (RULE9) Read/clear cause flags are set by hardware and cleared by software; write-only bits read as zero.
// (RULE10) A supply below threshold with its enable set raises a pending interrupt request.
`timescale 1ns/1ns
`include "sssg_regs.vh"
module sssg_supervisor (
	// Clock and reset
	input  wire                     clk_i,
	input  wire                     reset_n_i,
	// Register port
	input  wire [`SSSG_ADDR_W-1:0]  reg_addr_i,
	input  wire [`SSSG_DATA_W-1:0]  reg_wdata_i,
	input  wire                     reg_wr_i,
	input  wire                     reg_rd_i,
	output wire [`SSSG_DATA_W-1:0]  reg_rdata_o,
	// Analog comparators, watchdog and supply interrupt acknowledge
	input  wire                     supply_low_i,
	input  wire                     reset_comparator_state_i,
	input  wire                     watchdog_expired_i,
	input  wire                     supply_irq_ack_i,
	// Supervisor controls
	output wire [1:0]               reset_trip_level_o,
	output wire                     high_trip_selected_o,
	output wire [2:0]               detector_threshold_select_o,
	output wire                     threshold_above_reset_o,
	output wire                     power_on_reset_o,
	// Clock and power controls
	output wire [2:0]               cpu_speed_o,
	output wire [1:0]               sleep_timer_o,
	output wire                     no_buzz_o,
	output wire                     sleep_o,
	output wire                     stop_o,
	// Interrupt and watchdog
	output wire                     global_irq_state_o,
	output wire [`SSSG_DATA_W-1:0]  irq_enable_o,
	output wire                     supply_irq_o,
	output wire                     watchdog_clear_o
);
	wire [`SSSG_SEL_COUNT-1:0] sel;
	wire                       powerup_cause_flag;
	wire                       watchdog_cause_flag;
	wire                       supply_irq_pending;
	wire                       wr_scr;
	wire                       scr_clear_por;
	wire                       scr_clear_wdr;
	wire                       supply_irq_set;

	reg  [`SSSG_DATA_W-1:0]    irq_enable_reg;
	reg  [`SSSG_DATA_W-1:0]    cpu_flags_reg;
	reg                        sleep_reg;
	reg                        stop_reg;
	reg  [`SSSG_DATA_W-1:0]    osc_speed_reg;
	reg  [`SSSG_DATA_W-1:0]    vdet_ctrl_reg;
	reg  [1:0]                 vcmp_reg;
	reg                        por_reg;
	reg                        wdt_clear_reg;
	reg  [`SSSG_DATA_W-1:0]    rdata_reg;
	reg  [`SSSG_DATA_W-1:0]    rdata_next;

	// The sleep and stop reset bits of the system control register are picked from its full reset word.
	localparam [`SSSG_DATA_W-1:0] scr_reset_val = `SSSG_RST_SYS_CTRL;

	sssg_addr_decode u_decode (
		.addr_i      (reg_addr_i),
		.ext_space_i (cpu_flags_reg[`SSSG_FLAGS_EXT_BIT]),
		.sel_o       (sel)
	);

	assign wr_scr = reg_wr_i & sel[`SSSG_SEL_SYS_CTRL];

	// Cause flags clear only when software writes a zero into their place.
	assign scr_clear_por = wr_scr & ~reg_wdata_i[`SSSG_SCR_POR_BIT]; // RULE9
	assign scr_clear_wdr = wr_scr & ~reg_wdata_i[`SSSG_SCR_WDR_BIT]; // RULE9

	sssg_sticky_flag #(
		.RESET_VAL (1'b1)
	) u_por_cause (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.set_i     (por_reg),
		.clr_i     (scr_clear_por),
		.flag_o    (powerup_cause_flag)
	);

	sssg_sticky_flag #(
		.RESET_VAL (1'b0)
	) u_wdt_cause (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.set_i     (watchdog_expired_i),
		.clr_i     (scr_clear_wdr),
		.flag_o    (watchdog_cause_flag)
	);

	// The request keeps being set while the supply stays low and its enable is set, so an
	// acknowledge during a dip is refused until the supply has recovered.
	assign supply_irq_set = vcmp_reg[`SSSG_VCMP_LOW_BIT] & irq_enable_reg[`SSSG_IEN_SUPPLY_BIT]; // RULE10

	sssg_sticky_flag #(
		.RESET_VAL (1'b0)
	) u_supply_irq (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.set_i     (supply_irq_set),
		.clr_i     (supply_irq_ack_i),
		.flag_o    (supply_irq_pending)
	);

	// Interrupt enables.
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			irq_enable_reg <= `SSSG_RST_INT_EN0;
		else if (reg_wr_i && sel[`SSSG_SEL_INT_EN0])
			irq_enable_reg <= reg_wdata_i;
	end

	// Flags register, including the extended-space flag.
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			cpu_flags_reg <= `SSSG_RST_CPU_FLAGS;
		else if (reg_wr_i && sel[`SSSG_SEL_CPU_FLAGS])
			cpu_flags_reg <= reg_wdata_i & `SSSG_FLAGS_RW_MASK; // RULE1
	end

	// Sleep and stop requests of the system control register.
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sleep_reg <= scr_reset_val[`SSSG_SCR_SLEEP_BIT];
			stop_reg  <= scr_reset_val[`SSSG_SCR_STOP_BIT];
		end else if (wr_scr) begin
			sleep_reg <= reg_wdata_i[`SSSG_SCR_SLEEP_BIT];
			stop_reg  <= reg_wdata_i[`SSSG_SCR_STOP_BIT];
		end
	end

	// Oscillator speed control. Raising the speed is not blocked here: the
	// ordering against the trip level is firmware's duty, and blocking it would
	// break the fall-back sequence that lowers the trip while running slowly.
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			osc_speed_reg <= `SSSG_RST_OSC_SPEED;
		else if (reg_wr_i && sel[`SSSG_SEL_OSC_SPEED])
			osc_speed_reg <= reg_wdata_i; // RULE5
	end

	// Voltage detect control: trip level and detector threshold.
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			vdet_ctrl_reg <= `SSSG_RST_VDET_CTRL;
		else if (reg_wr_i && sel[`SSSG_SEL_VDET_CTRL])
			vdet_ctrl_reg <= reg_wdata_i & `SSSG_VDET_RW_MASK; // RULE2 RULE3
	end

	// Comparator status and reset request are sampled once, so the status
	// that firmware reads and the interrupt it gets agree to the cycle.
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			vcmp_reg <= 2'h0;
			por_reg  <= 1'b0;
		end else begin
			vcmp_reg[`SSSG_VCMP_LOW_BIT]   <= supply_low_i; // RULE4
			vcmp_reg[`SSSG_VCMP_RESET_BIT] <= reset_comparator_state_i;
			por_reg                        <= reset_comparator_state_i; // RULE6
		end
	end

	// Watchdog clear is a write-only strobe; it is never stored for reading.
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			wdt_clear_reg <= 1'b0;
		else
			wdt_clear_reg <= reg_wr_i & sel[`SSSG_SEL_WDT_CLR]; // RULE9
	end

	// Read multiplexer; unmapped and write-only addresses read zero.
	always @* begin
		rdata_next = {`SSSG_DATA_W{1'b0}};
		if (sel[`SSSG_SEL_INT_EN0])
			rdata_next = irq_enable_reg;
		if (sel[`SSSG_SEL_CPU_FLAGS])
			rdata_next = cpu_flags_reg;
		if (sel[`SSSG_SEL_SYS_CTRL]) begin
			rdata_next[`SSSG_SCR_GIRQ_BIT]  = cpu_flags_reg[`SSSG_FLAGS_GIE_BIT];
			rdata_next[`SSSG_SCR_WDR_BIT]   = watchdog_cause_flag; // RULE9
			rdata_next[`SSSG_SCR_POR_BIT]   = powerup_cause_flag; // RULE9
			rdata_next[`SSSG_SCR_SLEEP_BIT] = sleep_reg;
			rdata_next[`SSSG_SCR_STOP_BIT]  = stop_reg;
		end
		if (sel[`SSSG_SEL_OSC_SPEED])
			rdata_next = osc_speed_reg;
		if (sel[`SSSG_SEL_VDET_CTRL])
			rdata_next = vdet_ctrl_reg;
		if (sel[`SSSG_SEL_VCMP_STAT])
			rdata_next = {6'h00, vcmp_reg}; // RULE4
	end

	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			rdata_reg <= {`SSSG_DATA_W{1'b0}};
		else if (reg_rd_i)
			rdata_reg <= rdata_next;
		else
			rdata_reg <= {`SSSG_DATA_W{1'b0}};
	end

	assign reg_rdata_o                 = rdata_reg;
	assign reset_trip_level_o          = vdet_ctrl_reg[`SSSG_VDET_LEV_LSB +: 2];
	assign high_trip_selected_o        = (vdet_ctrl_reg[`SSSG_VDET_LEV_LSB +: 2] == `SSSG_LEV_HIGH); // RULE2
	assign detector_threshold_select_o = vdet_ctrl_reg[`SSSG_VDET_THR_LSB +: 3];
	assign threshold_above_reset_o     = (vdet_ctrl_reg[`SSSG_VDET_THR_LSB +: 3] == `SSSG_THR_HIGH_LOWER) |
	                                     (vdet_ctrl_reg[`SSSG_VDET_THR_LSB +: 3] == `SSSG_THR_HIGH_UPPER); // RULE3
	assign power_on_reset_o            = por_reg; // RULE6
	assign cpu_speed_o                 = osc_speed_reg[`SSSG_OSC_SPEED_LSB +: 3];
	assign sleep_timer_o               = osc_speed_reg[`SSSG_OSC_SLEEP_LSB +: 2];
	assign no_buzz_o                   = osc_speed_reg[`SSSG_OSC_NOBUZZ_BIT];
	assign sleep_o                     = sleep_reg;
	assign stop_o                      = stop_reg;
	assign global_irq_state_o          = cpu_flags_reg[`SSSG_FLAGS_GIE_BIT];
	assign irq_enable_o                = irq_enable_reg;
	assign supply_irq_o                = supply_irq_pending; // RULE10
	assign watchdog_clear_o            = wdt_clear_reg;
endmodule // sssg_supervisor

// File: sssg_chk_sva.sv
/*
 * Port checker of the supply supervisor, bound into sssg_supervisor.
 * Assumes one clock domain and the register map of sssg_regs.vh.
 */
`timescale 1ns/1ns
module sssg_chk (
	// Clock, reset and register port
	input wire       clk_i,
	input wire       reset_n_i,
	input wire [8:0] reg_addr_i,
	input wire       reg_wr_i,
	input wire       reg_rd_i,
	input wire [7:0] reg_rdata_o,
	// Supervisor side
	input wire       supply_low_i,
	input wire       reset_comparator_state_i,
	input wire       supply_irq_ack_i,
	input wire [1:0] reset_trip_level_o,
	input wire       high_trip_selected_o,
	input wire [2:0] detector_threshold_select_o,
	input wire       threshold_above_reset_o,
	input wire       power_on_reset_o,
	input wire [7:0] irq_enable_o,
	input wire       supply_irq_o,
	input wire       watchdog_clear_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence low_seen_enabled;
		supply_low_i ##1 irq_enable_o[0];
	endsequence
	sequence wdt_write;
		reg_wr_i && reg_addr_i == 9'h0E3;
	endsequence
	a_trip_decode: assert property (high_trip_selected_o == (reset_trip_level_o == 2'h2))
		else $error("trip decode wrong");
	a_trip_write: assert property ($changed(reset_trip_level_o) |-> $past(reg_wr_i && reg_addr_i == 9'h1E3))
		else $error("trip level moved without a write");
	a_threshold_high: assert property (threshold_above_reset_o == (detector_threshold_select_o[2:1] == 2'h3))
		else $error("threshold decode wrong");
	a_por_follows: assert property (power_on_reset_o == $past(reset_comparator_state_i))
		else $error("reset output not one cycle behind comparator");
	a_irq_raise: assert property (low_seen_enabled |=> supply_irq_o)
		else $error("supply interrupt not raised");
	a_irq_sticky: assert property (supply_irq_o && !supply_irq_ack_i |=> supply_irq_o)
		else $error("supply interrupt lost without ack");
	a_wdt_pulse: assert property (wdt_write |=> watchdog_clear_o)
		else $error("watchdog clear pulse missing");
	a_wdt_only: assert property (watchdog_clear_o |-> $past(reg_wr_i && reg_addr_i == 9'h0E3))
		else $error("watchdog clear without write");
	a_wo_readzero: assert property (reg_rd_i && reg_addr_i == 9'h0E3 |=> reg_rdata_o == 8'h00)
		else $error("write-only register read back");
endmodule // sssg_chk
bind sssg_supervisor sssg_chk chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .supply_low_i(supply_low_i),
	.reset_comparator_state_i(reset_comparator_state_i), .supply_irq_ack_i(supply_irq_ack_i),
	.reset_trip_level_o(reset_trip_level_o), .high_trip_selected_o(high_trip_selected_o),
	.detector_threshold_select_o(detector_threshold_select_o), .threshold_above_reset_o(threshold_above_reset_o),
	.power_on_reset_o(power_on_reset_o), .irq_enable_o(irq_enable_o), .supply_irq_o(supply_irq_o),
	.watchdog_clear_o(watchdog_clear_o));

// File: sssg_tb.sv
/*
 * Self-checking testbench of the supply supervisor: register rows, then hand tests.
 * Assumes the design files and the checker are compiled before it.
 */
`timescale 1ns/1ns
module testbench;
	reg        clk_i = 1'h0;
	reg        reset_n_i = 1'h0;
	reg  [8:0] a = 9'h000;
	reg  [7:0] d = 8'h00;
	reg        wr = 1'h0, rd = 1'h0, lo = 1'h0, rc = 1'h0, wd = 1'h0, ack = 1'h0;
	wire [7:0] q, ie;
	wire [1:0] tl;
	wire [2:0] th;
	wire       hi, ab, por, irq, wc, nb, sl, so, gi;
	wire [2:0] sp;
	wire [1:0] st;
	integer    failures = 0, comparisons = 0, i;
	reg  [8:0] ta [0:4];
	reg  [7:0] td [0:4], te [0:4];
	sssg_supervisor dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(a), .reg_wdata_i(d), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(q), .supply_low_i(lo), .reset_comparator_state_i(rc), .watchdog_expired_i(wd),
		.supply_irq_ack_i(ack), .reset_trip_level_o(tl), .high_trip_selected_o(hi), .detector_threshold_select_o(th),
		.threshold_above_reset_o(ab), .power_on_reset_o(por), .cpu_speed_o(sp), .sleep_timer_o(st), .no_buzz_o(nb),
		.sleep_o(sl), .stop_o(so), .global_irq_state_o(gi), .irq_enable_o(ie), .supply_irq_o(irq), .watchdog_clear_o(wc));
	task close_out;
		begin
			if (failures == 0 && comparisons > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task c(input [7:0] g, input [7:0] e);
		begin
			comparisons = comparisons + 1;
			if (g !== e) begin
				failures = failures + 1;
				$display("wrong value at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	// Strobes start one edge later than the last one fell, so no signal is driven twice in a step.
	task w(input [8:0] x, input [7:0] y);
		begin
			@(posedge clk_i);
			a <= x;
			d <= y;
			wr <= 1'h1;
			@(posedge clk_i);
			wr <= 1'h0;
			#1;
		end
	endtask
	task r(input [8:0] x, input [7:0] e);
		begin
			@(posedge clk_i);
			a <= x;
			rd <= 1'h1;
			@(posedge clk_i);
			rd <= 1'h0;
			#1 c(q, e);
		end
	endtask
	task n(input integer k);
		begin
			repeat (k) @(posedge clk_i);
			#1;
		end
	endtask
	task p(input l, input m, input v, input k);
		begin
			@(posedge clk_i);
			lo <= l;
			rc <= m;
			wd <= v;
			ack <= k;
		end
	endtask
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		#50000;
		failures = failures + 1;
		close_out;
	end
	initial begin
		ta[0] = 9'h0F7; td[0] = 8'hF0; te[0] = 8'h10;
		// The supply enable stays off here, so the early low-supply tests raise no request.
		ta[1] = 9'h0E0; td[1] = 8'hA4; te[1] = 8'hA4;
		ta[2] = 9'h0E3; td[2] = 8'hFF; te[2] = 8'h00;
		ta[3] = 9'h1E0; td[3] = 8'hFF; te[3] = 8'hFF;
		ta[4] = 9'h1E3; td[4] = 8'hFF; te[4] = 8'h37;
		repeat (16) @(posedge clk_i);
		reset_n_i <= 1'h1;
		r(9'h0FF, 8'h10);
		r(9'h0F7, 8'h02);
		r(9'h0E0, 8'h00);
		w(9'h1E3, 8'h26);
		c(tl, 8'h00);
		r(9'h1E3, 8'h00);
		for (i = 0; i < 5; i = i + 1) begin
			w(ta[i], td[i]);
			r(ta[i], te[i]);
		end
		for (i = 0; i < 8; i = i + 1) begin
			w(9'h1E3, {2'h0, i[1:0], 1'h0, i[2:0]});
			c(th, i[2:0]);
			c(ab, i > 5);
			c(hi, i[1:0] == 2);
			c(tl, i[1:0]);
		end
		c(ie, 8'hA4);
		c(sp, 8'h07);
		c(st, 8'h03);
		c(nb, 8'h01);
		w(9'h1E3, 8'h06);
		c(ab, 8'h01);
		c(hi, 8'h00);
		p(1, 0, 0, 0);
		n(2);
		r(9'h1E4, 8'h02);
		p(0, 0, 0, 0);
		n(2);
		r(9'h1E4, 8'h00);
		r(9'h1E4, 8'h00);
		w(9'h1E3, 8'h26);
		c(hi, 8'h01);
		w(9'h1E0, 8'h2B);
		c(sp, 8'h03);
		c(st, 8'h01);
		c(nb, 8'h01);
		w(9'h0FF, 8'h00);
		r(9'h0FF, 8'h00);
		p(0, 1, 0, 0);
		n(2);
		c(por, 8'h01);
		r(9'h1E4, 8'h01);
		p(0, 0, 1, 0);
		p(0, 0, 0, 0);
		n(2);
		c(por, 8'h00);
		r(9'h0FF, 8'h30);
		w(9'h0FF, 8'h39);
		c(sl, 8'h01);
		c(so, 8'h01);
		w(9'h0F7, 8'h11);
		c(gi, 8'h01);
		r(9'h0FF, 8'hB9);
		// A clear that meets a live reset request must leave the power-up cause set.
		p(0, 1, 0, 0);
		n(1);
		w(9'h0FF, 8'h00);
		p(0, 0, 0, 0);
		n(2);
		r(9'h0FF, 8'h90);
		w(9'h0E3, 8'h5A);
		c(wc, 8'h01);
		w(9'h0E0, 8'h00);
		p(1, 0, 0, 0);
		n(4);
		c(irq, 8'h00);
		w(9'h0E0, 8'h01);
		c(ie, 8'h01);
		n(2);
		c(irq, 8'h01);
		w(9'h1E0, 8'h29);
		w(9'h1E3, 8'h06);
		c(sp, 8'h01);
		c(tl, 8'h00);
		p(0, 0, 0, 0);
		n(3);
		c(irq, 8'h01);
		p(0, 0, 0, 1);
		p(0, 0, 0, 0);
		n(1);
		c(irq, 8'h00);
		r(9'h1E4, 8'h00);
		w(9'h1E3, 8'h26);
		c(hi, 8'h01);
		w(9'h1E0, 8'h2B);
		c(sp, 8'h03);
		r(9'h1E5, 8'h00);
		r(9'h0E1, 8'h00);
		@(posedge clk_i);
		reset_n_i <= 1'h0;
		n(2);
		reset_n_i <= 1'h1;
		r(9'h1E0, 8'h00);
		r(9'h0F7, 8'h02);
		close_out;
	end
endmodule // testbench
